// ==== rtl/dsr_ctrl.sv ====
// Functional notes
// - phase up to fifteen delays that many cycles
// - phase sixteen up delays phase-16 plus low+1
// - each divider has its own phase offset
// - sync holds outputs static, resumes from preset
// - sync pin low then high syncs outputs
// - soft sync, soft reset, distribution power-down trigger sync
// - reset pin, sleep pin, power-up also sync
// - async sync pin gives one-cycle start uncertainty
// - clocking starts fifteen cycles after sync rise
// - sync register changes need update-all strobe
// - start-high and phase set static and resume
// - new phase waits for a sync
// - sync applies to all drivers of divider
// - ignore-sync channel keeps clocking, unaligned
// - per-output polarity and own power-down
// - single-ended mode turns on both halves
// - single-ended enables in bits 6:5; off tristates
// - power-on loads stored or built-in settings
// - power-up sync at 50 ms, toggling 70 ms
// - reset pin restores settings, then syncs outputs
// - bits 2 and 5 request soft reset
// - only bits 2 and 5 self-clear
// - soft reset ends after one more serial clock
// - phase value is start-high times sixteen plus offset
`include "dsr_regs.svh"

module dsr_ctrl #(
	parameter int unsigned POR_SYNC_CYC = `DSR_MS_CYC(`DSR_T_POR_SYNC_MS),
	parameter int unsigned POR_LIVE_CYC = `DSR_MS_CYC(`DSR_T_POR_LIVE_MS),
	parameter int unsigned STORE_LOAD_CYC = `DSR_MS_CYC(`DSR_T_STORE_LOAD_MS),
	parameter dsr_pkg::dsr_dev_cfg_t DEF_CFG = '0
) (
	// clock and power-on reset
	input wire logic clk_sys,
	input wire logic rstn,
	// device pins
	input wire logic syncPinN,
	input wire logic resetPinN,
	input wire logic sleepPinN,
	input wire logic storageSel,
	// serial control register
	input wire logic ctrlWr,
	input wire logic [7:0] ctrlIn,
	input wire logic sclkTick,
	// sync control register and update strobe
	input wire logic syncCtrlWr,
	input wire logic [1:0] syncCtrlIn,
	input wire logic updateAll,
	// configuration image
	input wire logic cfgWr,
	input wire dsr_pkg::dsr_dev_cfg_t cfgIn,
	input wire dsr_pkg::dsr_dev_cfg_t storedCfg,
	// output pins
	output dsr_pkg::dsr_pin_t [11:0] outPins,
	// status
	output logic [7:0] ctrlReg,
	output logic syncBusy,
	output logic inReset,
	output logic outLive
);

	localparam int SYNC_WAIT = `DSR_SYNC_PIPE_CYC - `DSR_SYNC_FIXED_CYC;

	dsr_pkg::dsr_state_t state;
	dsr_pkg::dsr_dev_cfg_t cfg;
	dsr_pkg::dsr_dev_cfg_t wrCfg;
	logic syncMeta;
	logic syncS2;
	logic [1:0] syncShadow;
	logic softSyncEff;
	logic distPdEff;
	logic softRst;
	logic syncReq;
	logic porLoaded;
	logic restore;
	logic [31:0] timer;
	logic [31:0] liveCnt;
	logic [31:0] loadLim;
	logic divHold;
	logic drvOff;
	logic [3:0] divClk;

	// sync pin synchroniser; the start may slip one cycle with pin timing
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncMeta <= 1'b1;
			syncS2 <= 1'b1;
		end else begin
			syncMeta <= syncPinN;
			syncS2 <= syncMeta;
		end
	end

	// sync control: writes land in a shadow, update-all makes them live
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncShadow <= 2'h0;
			softSyncEff <= 1'b0;
			distPdEff <= 1'b0;
		end else begin
			if (syncCtrlWr) begin
				syncShadow <= syncCtrlIn;
			end
			if (updateAll) begin
				softSyncEff <= syncShadow[`DSR_BIT_SOFT_SYNC];
				distPdEff <= syncShadow[`DSR_BIT_DIST_PD];
			end
		end
	end

	// any active source holds the outputs; releasing it starts the sync
	assign syncReq = !syncS2 || softSyncEff || distPdEff || !sleepPinN;

	// serial control register; soft reset bits clear on the next serial clock
	assign softRst = ctrlReg[`DSR_BIT_SOFT_RST_LO] && ctrlReg[`DSR_BIT_SOFT_RST_HI];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrlReg <= `DSR_CTRL_RST;
		end else if (ctrlWr) begin
			ctrlReg <= ctrlIn;
		end else if (softRst && sclkTick) begin
			ctrlReg[`DSR_BIT_SOFT_RST_LO] <= 1'b0;
			ctrlReg[`DSR_BIT_SOFT_RST_HI] <= 1'b0;
		end
	end

	// restore runs on the first cycle after power-on and throughout any reset
	assign restore = (state == dsr_pkg::ST_RESET) || !porLoaded;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			porLoaded <= 1'b0;
		end else begin
			porLoaded <= 1'b1;
		end
	end

	// entering single-ended mode switches both halves on
	always_comb begin
		wrCfg = cfgIn;
		for (int i = 0; i < `DSR_NUM_OUT; i++) begin
			if (cfgIn.outs[i].cmosMode && !cfg.outs[i].cmosMode) begin
				wrCfg.outs[i].enA = 1'b1;
				wrCfg.outs[i].enB = 1'b1;
			end
		end
	end

	// the strap is read by this clocked process, never by the reset itself
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg <= DEF_CFG;
		end else if (restore) begin
			cfg <= storageSel ? storedCfg : DEF_CFG;
		end else if (cfgWr) begin
			cfg <= wrCfg;
		end
	end

	// stored settings take far longer to come back than built-in ones
	assign loadLim = storageSel ? 32'(STORE_LOAD_CYC) : 32'(`DSR_DEF_LOAD_CYC);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state <= dsr_pkg::ST_POR;
			timer <= 32'h0000_0000;
		end else if (!resetPinN || softRst) begin
			state <= dsr_pkg::ST_RESET;
			timer <= 32'h0000_0000;
		end else begin
			case (state)
				dsr_pkg::ST_POR: begin
					if (timer == 32'(POR_SYNC_CYC - 1)) begin
						state <= dsr_pkg::ST_PIPE;
						timer <= 32'h0000_0000;
					end else begin
						timer <= timer + 32'h0000_0001;
					end
				end
				dsr_pkg::ST_RESET: begin
					state <= dsr_pkg::ST_LOAD;
					timer <= 32'h0000_0000;
				end
				dsr_pkg::ST_LOAD: begin
					if (timer >= loadLim - 32'h0000_0001) begin
						state <= syncReq ? dsr_pkg::ST_HOLD : dsr_pkg::ST_PIPE;
						timer <= 32'h0000_0000;
					end else begin
						timer <= timer + 32'h0000_0001;
					end
				end
				dsr_pkg::ST_HOLD: begin
					if (!syncReq) begin
						state <= dsr_pkg::ST_PIPE;
					end
					timer <= 32'h0000_0000;
				end
				dsr_pkg::ST_PIPE: begin
					if (syncReq) begin
						state <= dsr_pkg::ST_HOLD;
						timer <= 32'h0000_0000;
					end else if (timer == 32'(SYNC_WAIT - 1)) begin
						state <= dsr_pkg::ST_RUN;
						timer <= 32'h0000_0000;
					end else begin
						timer <= timer + 32'h0000_0001;
					end
				end
				dsr_pkg::ST_RUN: begin
					if (syncReq) begin
						state <= dsr_pkg::ST_HOLD;
					end
					timer <= 32'h0000_0000;
				end
				default: begin
					state <= dsr_pkg::ST_POR;
					timer <= 32'h0000_0000;
				end
			endcase
		end
	end

	// outputs first toggle once the power-on settle time is over
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			liveCnt <= 32'h0000_0000;
			outLive <= 1'b0;
		end else if (!outLive) begin
			if (liveCnt == 32'(POR_LIVE_CYC - 1)) begin
				outLive <= 1'b1;
			end
			liveCnt <= liveCnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncBusy <= 1'b1;
			inReset <= 1'b1;
		end else begin
			syncBusy <= (state != dsr_pkg::ST_RUN);
			inReset <= (state == dsr_pkg::ST_RESET) || (state == dsr_pkg::ST_POR);
		end
	end

	// static outputs during reset and sync; sleep tristates every driver
	assign divHold = (state != dsr_pkg::ST_RUN) || !outLive;
	assign drvOff = !sleepPinN;

	for (genvar c = 0; c < `DSR_NUM_CHAN; c++) begin : g_chan
		dsr_chan_div u_div (
			.clk_sys(clk_sys),
			.rstn(rstn),
			.cfg(cfg.chan[c]),
			.syncHold(divHold),
			.divOut(divClk[c])
		);
	end

	// three drivers share each divider and so each sync condition
	for (genvar o = 0; o < `DSR_NUM_OUT; o++) begin : g_out
		dsr_out_drv u_drv (
			.clk_sys(clk_sys),
			.rstn(rstn),
			.cfg(cfg.outs[o]),
			.clkIn(divClk[o / `DSR_OUT_PER_CHAN]),
			.forceOff(drvOff),
			.pin(outPins[o])
		);
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_sync_pipe;
		$past(state) == dsr_pkg::ST_PIPE && state == dsr_pkg::ST_RUN |-> $past(timer) == 32'(SYNC_WAIT - 1);
	endproperty
	a_sync_pipe: assert property (p_sync_pipe) else $error("sync pipeline length wrong");

	sequence s_pin_release;
		!syncS2 ##1 syncS2;
	endsequence
	property p_pin_sync;
		s_pin_release ##0 (state == dsr_pkg::ST_HOLD && resetPinN && !softRst && !softSyncEff
			&& !distPdEff && sleepPinN) |=> state == dsr_pkg::ST_PIPE;
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("pin release did not start sync");

	property p_synchroniser;
		##2 1'b1 |-> syncS2 == $past(syncPinN, 2);
	endproperty
	a_synchroniser: assert property (p_synchroniser) else $error("sync pin latency wrong");

	property p_update_gate;
		!updateAll |=> softSyncEff == $past(softSyncEff) && distPdEff == $past(distPdEff);
	endproperty
	a_update_gate: assert property (p_update_gate) else $error("sync bit moved without update");

	sequence s_soft_write;
		ctrlWr && ctrlIn[`DSR_BIT_SOFT_RST_LO] && ctrlIn[`DSR_BIT_SOFT_RST_HI];
	endsequence
	property p_soft_enter;
		s_soft_write |=> ##1 state == dsr_pkg::ST_RESET;
	endproperty
	a_soft_enter: assert property (p_soft_enter) else $error("soft reset not entered");

	property p_soft_wait;
		softRst && !sclkTick && !ctrlWr |=> softRst ##1 state == dsr_pkg::ST_RESET;
	endproperty
	a_soft_wait: assert property (p_soft_wait) else $error("soft reset ended early");

	property p_self_clear;
		softRst && sclkTick && !ctrlWr |=> !ctrlReg[`DSR_BIT_SOFT_RST_LO]
			&& !ctrlReg[`DSR_BIT_SOFT_RST_HI] && ctrlReg[7:6] == $past(ctrlReg[7:6])
			&& ctrlReg[4:3] == $past(ctrlReg[4:3]) && ctrlReg[1:0] == $past(ctrlReg[1:0]);
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("wrong bits self-cleared");

	property p_restore;
		state == dsr_pkg::ST_RESET |=> cfg == ($past(storageSel) ? $past(storedCfg) : DEF_CFG);
	endproperty
	a_restore: assert property (p_restore) else $error("settings not restored");

	property p_se_auto;
		cfgWr && !restore && cfgIn.outs[0].cmosMode && !cfg.outs[0].cmosMode
			|=> cfg.outs[0].enA && cfg.outs[0].enB;
	endproperty
	a_se_auto: assert property (p_se_auto) else $error("single-ended halves not enabled");

	property p_reset_static;
		state == dsr_pkg::ST_RESET |-> divHold;
	endproperty
	a_reset_static: assert property (p_reset_static) else $error("outputs not held in reset");

endmodule : dsr_ctrl

// ==== rtl/dsr_regs.svh ====
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

// clock rate and structure
`define DSR_CLK_MHZ 40
`define DSR_NUM_CHAN 4
`define DSR_OUT_PER_CHAN 3
`define DSR_NUM_OUT 12

// phase value split point between the two delay cases
`define DSR_PHI_SPLIT 5'h10

// serial control register and its soft reset bits
`define DSR_REG_SERIAL_CTRL 16'h0000
`define DSR_BIT_SOFT_RST_LO 2
`define DSR_BIT_SOFT_RST_HI 5
`define DSR_CTRL_RST 8'h00

// sync control register, update register
`define DSR_REG_SYNC_CTRL 16'h0230
`define DSR_BIT_SOFT_SYNC 0
`define DSR_BIT_DIST_PD 1
`define DSR_REG_UPDATE 16'h0232
`define DSR_BIT_UPDATE 0

// per-output driver registers, single-ended enables in [6:5]
`define DSR_REG_OUT_FIRST 16'h00F0
`define DSR_REG_OUT_LAST 16'h00FB
`define DSR_BIT_SE_EN_A 5
`define DSR_BIT_SE_EN_B 6

// phase register of divider 0, start-high in bit 4
`define DSR_REG_PHASE_CH0 16'h0191
`define DSR_BIT_START_HIGH 4

// sync pipeline: 14 cycles plus one extra, four of them spent in fixed flops
`define DSR_SYNC_PIPE_MIN 14
`define DSR_SYNC_PIPE_EXTRA 1
`define DSR_SYNC_PIPE_CYC (`DSR_SYNC_PIPE_MIN + `DSR_SYNC_PIPE_EXTRA)
`define DSR_SYNC_FIXED_CYC 4

// times in their own units, and cycle counts derived from them
`define DSR_T_POR_SYNC_MS 50
`define DSR_T_POR_LIVE_MS 70
`define DSR_T_STORE_LOAD_MS 20
`define DSR_T_DEF_LOAD_US 2
`define DSR_MS_CYC(ms) ((ms) * 1000 * `DSR_CLK_MHZ)
`define DSR_DEF_LOAD_CYC (`DSR_T_DEF_LOAD_US * `DSR_CLK_MHZ)

`endif

// ==== rtl/dsr_pkg.sv ====
package dsr_pkg;

	typedef struct packed {
		logic ignoreSync;
		logic startHigh;
		logic [3:0] phaseOffset;
		logic [3:0] lowCycles;
		logic [3:0] highCycles;
	} dsr_chan_cfg_t;

	typedef struct packed {
		logic cmosMode;
		logic polA;
		logic polB;
		logic enA;
		logic enB;
		logic powerDown;
	} dsr_out_cfg_t;

	typedef struct packed {
		dsr_chan_cfg_t [3:0] chan;
		dsr_out_cfg_t [11:0] outs;
	} dsr_dev_cfg_t;

	typedef struct packed {
		logic outA;
		logic outB;
		logic oeAN;
		logic oeBN;
	} dsr_pin_t;

	typedef enum logic [2:0] {
		ST_POR,
		ST_RESET,
		ST_LOAD,
		ST_HOLD,
		ST_PIPE,
		ST_RUN
	} dsr_state_t;

endpackage : dsr_pkg

// ==== rtl/dsr_chan_div.sv ====
`include "dsr_regs.svh"

module dsr_chan_div (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// channel settings and sync hold
	input wire dsr_pkg::dsr_chan_cfg_t cfg,
	input wire logic syncHold,
	// divided clock
	output logic divOut
);

	logic hold;
	logic running;
	logic [4:0] dly;
	logic [3:0] cnt;
	logic [4:0] phi;
	logic [4:0] next_dly;
	logic [4:0] relCnt;
	logic [4:0] relDly;

	// an excluded channel never sees the hold
	assign hold = syncHold && !cfg.ignoreSync;
	assign phi = {cfg.startHigh, cfg.phaseOffset};

	always_comb begin
		if (phi < `DSR_PHI_SPLIT) begin
			next_dly = phi;
		end else begin
			next_dly = 5'({1'b0, cfg.phaseOffset}) + 5'({1'b0, cfg.lowCycles}) + 5'h01;
		end
	end

	// the delay is loaded only while held, so a new phase waits for a sync
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			running <= 1'b0;
			dly <= 5'h00;
			cnt <= 4'h0;
			divOut <= 1'b0;
		end else if (hold) begin
			running <= 1'b0;
			dly <= next_dly;
			cnt <= 4'h0;
			divOut <= cfg.startHigh;
		end else if (!running) begin
			if (dly == 5'h00) begin
				running <= 1'b1;
				divOut <= 1'b1;
				cnt <= cfg.highCycles;
			end else begin
				dly <= dly - 5'h01;
			end
		end else if (cnt == 4'h0) begin
			divOut <= !divOut;
			cnt <= divOut ? cfg.lowCycles : cfg.highCycles;
		end else begin
			cnt <= cnt - 4'h1;
		end
	end

	// cycles since release, for checking the first edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			relCnt <= 5'h00;
			relDly <= 5'h00;
		end else if (hold) begin
			relCnt <= 5'h00;
			relDly <= next_dly;
		end else if (!running) begin
			relCnt <= relCnt + 5'h01;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_first_edge;
		$rose(running) |-> divOut && (relCnt == relDly + 5'h01);
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("first edge off its phase delay");

	property p_static_hold;
		hold |=> !running && (divOut == $past(cfg.startHigh));
	endproperty
	a_static_hold: assert property (p_static_hold) else $error("held output not static");

	property p_ignore;
		syncHold && cfg.ignoreSync && running |=> running;
	endproperty
	a_ignore: assert property (p_ignore) else $error("excluded channel stopped");

endmodule : dsr_chan_div

// ==== rtl/dsr_out_drv.sv ====
module dsr_out_drv (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// driver settings and clock
	input wire dsr_pkg::dsr_out_cfg_t cfg,
	input wire logic clkIn,
	input wire logic forceOff,
	// pin signals, enables active low
	output dsr_pkg::dsr_pin_t pin
);

	dsr_pkg::dsr_pin_t next_pin;

	always_comb begin
		next_pin.outA = clkIn ^ cfg.polA;
		next_pin.outB = !(clkIn ^ cfg.polA);
		next_pin.oeAN = 1'b0;
		next_pin.oeBN = 1'b0;
		if (forceOff || cfg.powerDown) begin
			next_pin.outA = 1'b0;
			next_pin.outB = 1'b0;
			next_pin.oeAN = 1'b1;
			next_pin.oeBN = 1'b1;
		end else if (cfg.cmosMode) begin
			next_pin.outB = clkIn ^ cfg.polB;
			next_pin.oeAN = !cfg.enA;
			next_pin.oeBN = !cfg.enB;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin <= 4'h3;
		end else begin
			pin <= next_pin;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_power_down;
		forceOff || cfg.powerDown |=> pin.oeAN && pin.oeBN;
	endproperty
	a_power_down: assert property (p_power_down) else $error("powered-down output driven");

	property p_se_enable;
		!forceOff && !cfg.powerDown && cfg.cmosMode |=> (pin.oeAN == !$past(cfg.enA))
			&& (pin.oeBN == !$past(cfg.enB)) && (pin.outB == ($past(clkIn) ^ $past(cfg.polB)));
	endproperty
	a_se_enable: assert property (p_se_enable) else $error("single-ended enable wrong");

	property p_diff;
		!forceOff && !cfg.powerDown && !cfg.cmosMode |=> (pin.outA != pin.outB)
			&& !pin.oeAN && (pin.outA == ($past(clkIn) ^ $past(cfg.polA)));
	endproperty
	a_diff: assert property (p_diff) else $error("differential pair wrong");

endmodule : dsr_out_drv

// ==== sim/dsr_host_model.sv ====
module dsr_host_model (
	// clock
	input wire logic clk_sys,
	// sync pin and serial control strobes
	output logic syncPinN,
	output logic ctrlWr,
	output logic [7:0] ctrlIn,
	output logic sclkTick,
	output logic syncCtrlWr,
	output logic [1:0] syncCtrlIn,
	output logic updateAll
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		syncPinN = 1'b1;
		ctrlWr = 1'b0;
		ctrlIn = 8'h00;
		sclkTick = 1'b0;
		syncCtrlWr = 1'b0;
		syncCtrlIn = 2'h0;
		updateAll = 1'b0;
	end

	// pin is held low for n cycles, then released high
	task pin_sync(input int n);
		@(posedge clk_sys) #1 syncPinN = 1'b0;
		repeat (n) @(posedge clk_sys);
		#1 syncPinN = 1'b1;
	endtask : pin_sync

	// update strobe a cycle after the write, so the new shadow is copied
	task sync_write(input logic [1:0] v, input logic upd);
		@(posedge clk_sys) #1 syncCtrlWr = 1'b1;
		syncCtrlIn = v;
		@(posedge clk_sys) #1 syncCtrlWr = 1'b0;
		updateAll = upd;
		@(posedge clk_sys) #1 updateAll = 1'b0;
	endtask : sync_write

	task ctrl_write(input logic [7:0] v);
		@(posedge clk_sys) #1 ctrlWr = 1'b1;
		ctrlIn = v;
		@(posedge clk_sys) #1 ctrlWr = 1'b0;
	endtask : ctrl_write

	// one further serial clock lets the soft reset finish
	task sclk_cycle();
		@(posedge clk_sys) #1 sclkTick = 1'b1;
		@(posedge clk_sys) #1 sclkTick = 1'b0;
	endtask : sclk_cycle

endmodule : dsr_host_model

// ==== sim/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys, rstn, resetPinN, sleepPinN, storageSel, cfgWr;
	logic syncPinN, ctrlWr, sclkTick, syncCtrlWr, updateAll;
	logic [7:0] ctrlIn, ctrlReg;
	logic [1:0] syncCtrlIn;
	logic syncBusy, inReset, outLive;
	dsr_pkg::dsr_dev_cfg_t cfgIn, storedCfg, cf;
	dsr_pkg::dsr_pin_t [11:0] outPins, snap;
	logic [15:0] lfsr = 16'hF96D;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n, t0, t9;

	// short counts keep the run small; expectations use the same figures
	dsr_ctrl #(.POR_SYNC_CYC(20), .POR_LIVE_CYC(30), .STORE_LOAD_CYC(16)) dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .syncPinN(syncPinN), .resetPinN(resetPinN),
		.sleepPinN(sleepPinN), .storageSel(storageSel), .ctrlWr(ctrlWr), .ctrlIn(ctrlIn),
		.sclkTick(sclkTick), .syncCtrlWr(syncCtrlWr), .syncCtrlIn(syncCtrlIn),
		.updateAll(updateAll), .cfgWr(cfgWr), .cfgIn(cfgIn), .storedCfg(storedCfg),
		.outPins(outPins), .ctrlReg(ctrlReg), .syncBusy(syncBusy), .inReset(inReset),
		.outLive(outLive)
	);

	dsr_host_model host_u (
		.clk_sys(clk_sys), .syncPinN(syncPinN), .ctrlWr(ctrlWr), .ctrlIn(ctrlIn),
		.sclkTick(sclkTick), .syncCtrlWr(syncCtrlWr), .syncCtrlIn(syncCtrlIn),
		.updateAll(updateAll)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd

	// first output change after release, counted from a zero-offset channel
	function automatic int exp_first(input dsr_pkg::dsr_chan_cfg_t c);
		int d;
		d = c.startHigh ? int'(c.phaseOffset) + int'(c.lowCycles) + 1 : int'(c.phaseOffset);
		return c.startHigh ? d + int'(c.highCycles) + 1 : d;
	endfunction : exp_first

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task chkn(input string nm, input int e, input int g);
		samples_checked++;
		if (g != e) begin
			mismatches++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chkn

	task wait_busy(input int lim);
		n = 0;
		while (syncBusy !== 1'b0 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		chk("syncBusy", 1'b0, syncBusy);
	endtask : wait_busy

	task cfg_write(input dsr_pkg::dsr_dev_cfg_t v);
		@(posedge clk_sys) #1 cfgWr = 1'b1;
		cfgIn = v;
		@(posedge clk_sys) #1 cfgWr = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask : cfg_write

	task measure(input dsr_pkg::dsr_dev_cfg_t v);
		logic [3:0] lvl;
		int first [4];
		cfg_write(v);
		host_u.pin_sync(12);
		for (int c = 0; c < 4; c++) begin
			lvl[c] = outPins[3 * c].outA;
			first[c] = -1;
			chk("hold level", v.chan[c].startHigh, lvl[c]);
		end
		for (int k = 1; k <= 90; k++) begin
			@(negedge clk_sys);
			for (int c = 0; c < 4; c++)
				if (first[c] < 0 && outPins[3 * c].outA !== lvl[c])
					first[c] = k;
		end
		chkn("start window", 1, int'(first[0] - exp_first(v.chan[0]) inside {[15:18]}));
		for (int c = 1; c < 4; c++)
			chkn("relative delay", exp_first(v.chan[c]) - exp_first(v.chan[0]),
				first[c] - first[0]);
		wait_busy(20);
	endtask : measure

	task results();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	initial begin
		rstn = 1'b0;
		resetPinN = 1'b1;
		sleepPinN = 1'b1;
		storageSel = 1'b0;
		cfgWr = 1'b0;
		cfgIn = '0;
		storedCfg = '0;
		repeat (16) @(negedge clk_sys);
		chk("ctrlReg", 8'h00, ctrlReg);
		chk("inReset", 1'b1, inReset);
		chk("outLive", 1'b0, outLive);
		chk("oe in reset", 1'b1, outPins[0].oeAN);
		@(posedge clk_sys) #1 rstn = 1'b1;
		wait_busy(60);
		chkn("power-up wait", 1, int'(n inside {[30:40]}));
		chk("outLive", 1'b1, outLive);
		// corner phases: 0, 15, 16 and 31, random divide ratios
		cf = '0;
		for (int c = 0; c < 4; c++) begin
			cf.chan[c].lowCycles = 4'(rnd());
			cf.chan[c].highCycles = 4'(rnd());
			cf.chan[c].startHigh = c[1];
			cf.chan[c].phaseOffset = c[0] ? 4'hF : 4'h0;
		end
		measure(cf);
		for (int c = 0; c < 4; c++)
			cf.chan[c] = {1'b0, 13'(rnd())};
		measure(cf);
		// software sync with channel 3 excluded
		cf.chan[3].ignoreSync = 1'b1;
		cf.chan[3].lowCycles = 4'h1;
		cfg_write(cf);
		for (int b = 0; b < 2; b++) begin
			host_u.sync_write(2'(1 << b), 1'b0);
			repeat (3) @(negedge clk_sys);
			chk("busy before update", 1'b0, syncBusy);
			host_u.sync_write(2'(1 << b), 1'b1);
			// the held level reaches the pins one edge after busy rises
			repeat (4) @(negedge clk_sys);
			chk("busy after update", 1'b1, syncBusy);
			snap = outPins;
			t0 = 0;
			t9 = 0;
			repeat (40) begin
				@(negedge clk_sys);
				for (int o = 0; o < 9; o++)
					t0 += int'(outPins[o].outA !== snap[o].outA);
				t9 += int'(outPins[9].outA !== snap[9].outA);
				snap = outPins;
			end
			chkn("included toggles", 0, t0);
			chkn("excluded runs", 1, int'(t9 > 0));
			host_u.sync_write(2'h0, 1'b0);
			repeat (3) @(negedge clk_sys);
			chk("clear waits update", 1'b1, syncBusy);
			host_u.sync_write(2'h0, 1'b1);
			wait_busy(40);
		end
		// soft reset restores defaults, keeps other bits
		cf = '0;
		cf.outs[0].powerDown = 1'b1;
		cfg_write(cf);
		chk("powered down", 1'b1, outPins[0].oeAN);
		host_u.ctrl_write(8'hA5);
		@(negedge clk_sys);
		chk("ctrlReg", 8'hA5, ctrlReg);
		repeat (3) @(negedge clk_sys);
		chk("inReset", 1'b1, inReset);
		snap = outPins;
		repeat (12) @(negedge clk_sys);
		chk("still reset", 1'b1, inReset);
		chkn("static outputs", 1, int'(snap === outPins));
		host_u.sclk_cycle();
		repeat (2) @(negedge clk_sys);
		chk("self clear", 8'h81, ctrlReg);
		wait_busy(130);
		chkn("default load", 1, int'(n inside {[80:110]}));
		chk("defaults back", 1'b0, outPins[0].oeAN);
		// reset pin with stored image
		storedCfg = '0;
		storedCfg.outs[2].powerDown = 1'b1;
		storageSel = 1'b1;
		@(posedge clk_sys) #1 resetPinN = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk("pin reset", 1'b1, inReset);
		@(posedge clk_sys) #1 resetPinN = 1'b1;
		wait_busy(80);
		chkn("stored load", 1, int'(n inside {[16:45]}));
		chk("stored image", 1'b1, outPins[2].oeAN);
		// sleep pin tristates and then syncs
		@(posedge clk_sys) #1 sleepPinN = 1'b0;
		repeat (4) @(negedge clk_sys);
		for (int o = 0; o < 12; o++)
			chk("sleep tristate", 1'b1, outPins[o].oeAN);
		@(posedge clk_sys) #1 sleepPinN = 1'b1;
		wait_busy(40);
		// single-ended pairs, enables and polarity
		cf = '0;
		cf.outs[0].cmosMode = 1'b1;
		cf.outs[1].polA = 1'b1;
		cfg_write(cf);
		chk("cmos A on", 1'b0, outPins[0].oeAN);
		chk("cmos B on", 1'b0, outPins[0].oeBN);
		cf.outs[0].enA = 1'b1;
		cf.outs[0].polB = 1'b1;
		cfg_write(cf);
		chk("cmos B off", 1'b1, outPins[0].oeBN);
		chk("cmos A kept", 1'b0, outPins[0].oeAN);
		t0 = 0;
		repeat (20) begin
			@(negedge clk_sys);
			t0 += int'(outPins[1].outA !== ~outPins[2].outA);
			t0 += int'(outPins[2].outB !== ~outPins[2].outA);
			t0 += int'(outPins[0].outB !== ~outPins[0].outA);
		end
		chkn("inverted polarity", 0, t0);
		results();
	end

endmodule : tb
